// ---- logic/bcp_defines.vh ----
// Constants for the motor commutation PWM block
// What this block does
// - Six independent PWM outputs, center or edge aligned
// - Reload interrupt every one, two, four, eight reloads
// - Override mode drives all six pins from software
// - Counter and comparators keep running while overridden
// - One 8-bit pattern sets the whole bridge
// - Complementary pairs get dead time between transitions
// - Dead time is an 8-bit cycle count
// - Dead-time register accepts first write only
// - Phase current polarity picks top or bottom width
// - Each commutation state leaves one phase open
// - Same PWM on top and diagonal bottom transistor
// - Six-state table of top and bottom pairs
// - Buffered settings apply only after load permit
// - Center mode uses 12-bit up/down counter to modulus
// - Enabled fault forces outputs off at once
`ifndef BCP_DEFINES_VH
`define BCP_DEFINES_VH
// Register word indices
`define BCP_REG_CTRL 4'h0
`define BCP_REG_MOD 4'h1
`define BCP_REG_DUTY0 4'h2
`define BCP_REG_DEAD 4'h8
`define BCP_REG_OVR 4'h9
`define BCP_REG_STATE 4'hA
`define BCP_REG_FEN 4'hB
`define BCP_REG_ISTAT 4'hC
`define BCP_REG_IMASK 4'hD
`define BCP_REG_CNT 4'hE
`define BCP_REG_SENSE 4'hF
// Control register bit positions
`define BCP_CTRL_RUN 0
`define BCP_CTRL_CENTER 1
`define BCP_CTRL_COMP 2
`define BCP_CTRL_OVR 3
`define BCP_CTRL_COMMUT 4
`define BCP_CTRL_RATE_LO 5
`define BCP_CTRL_RATE_HI 6
`define BCP_CTRL_LOAD 7
// Interrupt status bit positions
`define BCP_IRQ_RELOAD 0
`define BCP_IRQ_FAULT 1
// Reset values
`define BCP_CTRL_RST 7'h00
`define BCP_MOD_RST 12'hFFF
`define BCP_DUTY_RST 12'h000
`define BCP_DEAD_RST 8'h00
`define BCP_OVR_RST 8'h00
`endif

// ---- logic/bcp_deadtime.v ----
// Dead-time inserter for one complementary phase leg
`timescale 1ns/1ns
module bcp_deadtime #(
  parameter DW = 8
) (
  input wire sys_clk,
  input wire rst_n,
  input wire demand,
  input wire [DW-1:0] dead_cnt,
  output reg top_out,
  output reg bot_out
);

  // Last demand seen, and remaining off cycles
  reg prev_r;
  reg [DW-1:0] wait_r;

  ////////////////////////////////////////////////////////////////
  // Any demand edge turns both switches off for dead_cnt+1 cycles
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      wait_r <= {DW{1'b0}};
      top_out <= 1'b0;
      bot_out <= 1'b0;
    end else if (demand != prev_r) begin
      // Edge: both off, start the gap
      prev_r <= demand;
      wait_r <= dead_cnt;
      top_out <= 1'b0;
      bot_out <= 1'b0;
    end else if (wait_r != {DW{1'b0}}) begin
      // Still inside the gap
      wait_r <= wait_r - {{(DW-1){1'b0}}, 1'b1};
    end else begin
      // Gap over, drive the leg
      top_out <= prev_r;
      bot_out <= ~prev_r;
    end
  end

endmodule

// ---- logic/bcp_pwm.v ----
// Six-output motor PWM with commutation, override, dead time and faults
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ns
`include "bcp_defines.vh"
module bcp_pwm #(
  parameter CW = 12,
  parameter NFAULT = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire [NFAULT-1:0] fault_in,
  input wire [2:0] current_sense,
  output wire irq,
  output wire top_switch_phase_a,
  output wire bottom_switch_phase_a,
  output wire top_switch_phase_b,
  output wire bottom_switch_phase_b,
  output wire top_switch_phase_c,
  output wire bottom_switch_phase_c
);

  ////////////////////////////////////////////////////////////////
  // Declarations

  // Control fields
  reg [6:0] ctrl_r;
  reg load_permit_bit_r;
  // Buffered and active period and widths
  reg [CW-1:0] mod_buf_r;
  reg [CW-1:0] mod_act_r;
  reg [CW-1:0] duty_buf_r [0:5];
  reg [CW-1:0] duty_act_r [0:5];
  // Dead time and its write-once lock
  reg [7:0] dead_r;
  reg dead_lock_r;
  // Override pattern and commutation state
  reg [7:0] output_override_pattern_r;
  reg [2:0] state_r;
  // Fault enables
  reg [NFAULT-1:0] fen_r;
  // Interrupt status and mask
  reg [1:0] istat_r;
  reg [1:0] imask_r;
  // Period counter and direction
  reg [CW-1:0] cnt_r;
  reg [CW-1:0] cnt_nxt;
  reg dir_up_r;
  reg dir_up_nxt;
  // Reload divider for the interrupt rate
  reg [2:0] rld_div_r;
  // Registered pin levels
  reg [5:0] out_r;
  reg [5:0] out_nxt;
  // Loop index
  integer i;

  // Decoded control bits
  wire run = ctrl_r[`BCP_CTRL_RUN];
  wire center = ctrl_r[`BCP_CTRL_CENTER];
  wire comp = ctrl_r[`BCP_CTRL_COMP];
  wire ovr_en = ctrl_r[`BCP_CTRL_OVR];
  wire commut = ctrl_r[`BCP_CTRL_COMMUT];
  wire [1:0] rate = ctrl_r[`BCP_CTRL_RATE_HI:`BCP_CTRL_RATE_LO];

  // Write strobes per register
  wire wr_ctrl = reg_wr && (reg_addr == `BCP_REG_CTRL);
  wire wr_dead = reg_wr && (reg_addr == `BCP_REG_DEAD);
  wire wr_istat = reg_wr && (reg_addr == `BCP_REG_ISTAT);

  // Period start: counter at zero heading up
  wire reload = run && (cnt_r == {CW{1'b0}}) && !dir_up_r;

  // Reload interrupt divider terminal count
  wire [2:0] rld_top = (3'h1 << rate) - 3'h1;
  wire rld_evt = reload && (rld_div_r == rld_top);

  // Any enabled fault
  wire fault_now = |(fault_in & fen_r);

  ////////////////////////////////////////////////////////////////
  // Functions

  // Bridge mask per commutation state; bit order
  // 0 top A, 1 bottom A, 2 top B, 3 bottom B, 4 top C, 5 bottom C
  function [5:0] bcp_commut_mask;
    input [2:0] st;
    begin
      case (st)
        3'h0: bcp_commut_mask = 6'h06;
        3'h1: bcp_commut_mask = 6'h24;
        3'h2: bcp_commut_mask = 6'h21;
        3'h3: bcp_commut_mask = 6'h09;
        3'h4: bcp_commut_mask = 6'h18;
        3'h5: bcp_commut_mask = 6'h12;
        default: bcp_commut_mask = 6'h00;
      endcase
    end
  endfunction

  // Compare one width against the running counter
  function bcp_cmp;
    input [CW-1:0] c;
    input [CW-1:0] w;
    begin
      bcp_cmp = (c < w);
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Register writes

  // Software-owned configuration
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r <= `BCP_CTRL_RST;
      mod_buf_r <= `BCP_MOD_RST;
      output_override_pattern_r <= `BCP_OVR_RST;
      state_r <= 3'h0;
      fen_r <= {NFAULT{1'b0}};
      imask_r <= 2'h0;
      for (i = 0; i < 6; i = i + 1) begin
        duty_buf_r[i] <= `BCP_DUTY_RST;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `BCP_REG_CTRL: ctrl_r <= reg_wdata[6:0];
        `BCP_REG_MOD: mod_buf_r <= reg_wdata[CW-1:0];
        // One write holds every pin level at once
        `BCP_REG_OVR: output_override_pattern_r <= reg_wdata[7:0];
        `BCP_REG_STATE: state_r <= reg_wdata[2:0];
        `BCP_REG_FEN: fen_r <= reg_wdata[NFAULT-1:0];
        `BCP_REG_IMASK: imask_r <= reg_wdata[1:0];
        default: begin
          // Width buffers live at consecutive indices
          for (i = 0; i < 6; i = i + 1) begin
            if (reg_addr == `BCP_REG_DUTY0 + i[3:0]) begin
              duty_buf_r[i] <= reg_wdata[CW-1:0];
            end
          end
        end
      endcase
    end
  end

  // Dead time is locked after its first write
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      dead_r <= `BCP_DEAD_RST;
      dead_lock_r <= 1'b0;
    end else if (wr_dead && !dead_lock_r) begin
      dead_r <= reg_wdata[7:0];
      dead_lock_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Load permit and buffer transfer

  // Permit set by software, cleared when consumed; set wins
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      load_permit_bit_r <= 1'b0;
    end else if (wr_ctrl && reg_wdata[`BCP_CTRL_LOAD]) begin
      load_permit_bit_r <= 1'b1;
    end else if (reload) begin
      load_permit_bit_r <= 1'b0;
    end
  end

  // Active values change only at a permitted reload
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      mod_act_r <= `BCP_MOD_RST;
      for (i = 0; i < 6; i = i + 1) begin
        duty_act_r[i] <= `BCP_DUTY_RST;
      end
    end else if (reload && load_permit_bit_r) begin
      mod_act_r <= mod_buf_r;
      for (i = 0; i < 6; i = i + 1) begin
        duty_act_r[i] <= duty_buf_r[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Period counter, independent of override

  // Next count: up/down in center mode, up-only in edge mode
  always @* begin
    cnt_nxt = cnt_r;
    dir_up_nxt = dir_up_r;
    if (!run) begin
      // Stopped: park at period start
      cnt_nxt = {CW{1'b0}};
      dir_up_nxt = 1'b0;
    end else if (center) begin
      if (dir_up_r) begin
        // Turn around at the modulus
        if (cnt_r >= mod_act_r) begin
          dir_up_nxt = 1'b0;
          cnt_nxt = cnt_r - {{(CW-1){1'b0}}, 1'b1};
        end else begin
          cnt_nxt = cnt_r + {{(CW-1){1'b0}}, 1'b1};
        end
      end else if (cnt_r == {CW{1'b0}}) begin
        // Bottom reached, climb again
        dir_up_nxt = 1'b1;
        cnt_nxt = {{(CW-1){1'b0}}, 1'b1};
      end else begin
        cnt_nxt = cnt_r - {{(CW-1){1'b0}}, 1'b1};
      end
    end else begin
      // Edge mode wraps after modulus-1
      dir_up_nxt = 1'b0;
      if ({1'b0, cnt_r} + {{CW{1'b0}}, 1'b1} >= {1'b0, mod_act_r}) begin
        cnt_nxt = {CW{1'b0}};
      end else begin
        cnt_nxt = cnt_r + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Counter flops keep running in every output mode
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_r <= {CW{1'b0}};
      dir_up_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      dir_up_r <= dir_up_nxt;
    end
  end

  // Count reloads toward the selected interrupt rate
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rld_div_r <= 3'h0;
    end else if (rld_evt) begin
      rld_div_r <= 3'h0;
    end else if (reload) begin
      rld_div_r <= rld_div_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Comparators and complementary legs

  // Raw independent channels
  wire [5:0] raw_pwm;
  // Leg outputs after dead time
  wire [2:0] leg_top;
  wire [2:0] leg_bot;

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_cmp
      // One comparator per channel
      assign raw_pwm[g] = run && bcp_cmp(cnt_r, duty_act_r[g]);
    end
    for (g = 0; g < 3; g = g + 1) begin : g_leg
      // Current polarity selects the top or bottom width
      wire [CW-1:0] leg_w = current_sense[g] ? duty_act_r[2*g] : duty_act_r[2*g+1];
      wire leg_dem = run && bcp_cmp(cnt_r, leg_w);
      bcp_deadtime #(
        .DW(8)
      ) u_dt (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .demand(leg_dem),
        .dead_cnt(dead_r),
        .top_out(leg_top[g]),
        .bot_out(leg_bot[g])
      );
    end
  endgenerate

  // Interleave legs into pin order
  wire [5:0] comp_vec = {leg_bot[2], leg_top[2], leg_bot[1], leg_top[1],
                         leg_bot[0], leg_top[0]};

  // Commutation: channel 0 waveform on the masked pair
  wire [5:0] commut_vec = {6{raw_pwm[0]}} & bcp_commut_mask(state_r);

  ////////////////////////////////////////////////////////////////
  // Output selection

  // Priority: fault, override, commutation, complementary, independent
  always @* begin
    if (fault_now) begin
      out_nxt = 6'h00;
    end else if (ovr_en) begin
      out_nxt = output_override_pattern_r[5:0];
    end else if (commut) begin
      out_nxt = commut_vec;
    end else if (comp) begin
      out_nxt = comp_vec;
    end else begin
      out_nxt = raw_pwm;
    end
  end

  // All six pins register on the same edge
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      out_r <= 6'h00;
    end else begin
      out_r <= out_nxt;
    end
  end

  // Fault also gates the pins without waiting an edge
  wire [5:0] pins = out_r & ~{6{fault_now}};

  assign top_switch_phase_a = pins[0];
  assign bottom_switch_phase_a = pins[1];
  assign top_switch_phase_b = pins[2];
  assign bottom_switch_phase_b = pins[3];
  assign top_switch_phase_c = pins[4];
  assign bottom_switch_phase_c = pins[5];

  ////////////////////////////////////////////////////////////////
  // Interrupts

  // Sticky events, write one to clear, set wins over clear
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      istat_r <= 2'h0;
    end else begin
      istat_r[`BCP_IRQ_RELOAD] <= rld_evt ||
        (istat_r[`BCP_IRQ_RELOAD] && !(wr_istat && reg_wdata[`BCP_IRQ_RELOAD]));
      istat_r[`BCP_IRQ_FAULT] <= fault_now ||
        (istat_r[`BCP_IRQ_FAULT] && !(wr_istat && reg_wdata[`BCP_IRQ_FAULT]));
    end
  end

  // Level output while any unmasked bit is set
  assign irq = |(istat_r & imask_r);

  ////////////////////////////////////////////////////////////////
  // Register reads, data one cycle after the strobe

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `BCP_REG_CTRL: reg_rdata <= {8'h00, load_permit_bit_r, ctrl_r};
        `BCP_REG_MOD: reg_rdata <= {{(16-CW){1'b0}}, mod_buf_r};
        `BCP_REG_DEAD: reg_rdata <= {7'h00, dead_lock_r, dead_r};
        `BCP_REG_OVR: reg_rdata <= {8'h00, output_override_pattern_r};
        `BCP_REG_STATE: reg_rdata <= {13'h0000, state_r};
        `BCP_REG_FEN: reg_rdata <= {{(16-NFAULT){1'b0}}, fen_r};
        `BCP_REG_ISTAT: reg_rdata <= {14'h0000, istat_r};
        `BCP_REG_IMASK: reg_rdata <= {14'h0000, imask_r};
        `BCP_REG_CNT: reg_rdata <= {{(15-CW){1'b0}}, dir_up_r, cnt_r};
        `BCP_REG_SENSE: reg_rdata <= {7'h00, pins, current_sense[2:0]} & 16'h01FF;
        default: reg_rdata <= {{(16-CW){1'b0}}, duty_buf_r[reg_addr[2:0] - 3'h2]};
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// ---- bench/bcp_pwm_monitor.sv ----
// Port checker for the commutation PWM block
`timescale 1ns/1ns
`include "bcp_defines.vh"
module bcp_pwm_monitor #(
  parameter CW = 12,
  parameter NFAULT = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [NFAULT-1:0] fault_in,
  input wire [2:0] current_sense,
  input wire irq,
  input wire top_switch_phase_a,
  input wire bottom_switch_phase_a,
  input wire top_switch_phase_b,
  input wire bottom_switch_phase_b,
  input wire top_switch_phase_c,
  input wire bottom_switch_phase_c
);
  // Gates as one vector, phase a on top
  wire [5:0] pins;
  wire flt;
  wire cm;
  reg [7:0] ctrl_r;
  reg [2:0] state_r;
  reg [NFAULT-1:0] fen_r;
  reg [1:0] mask_r;
  reg [7:0] dead_r;
  reg lock_r;
  reg [7:0] key_r;
  assign pins = {top_switch_phase_a, bottom_switch_phase_a, top_switch_phase_b,
    bottom_switch_phase_b, top_switch_phase_c, bottom_switch_phase_c};
  assign flt = |(fault_in & fen_r);
  // Commutation selected, settled, no fault
  assign cm = ctrl_r[4] & ~ctrl_r[3] & (key_r == {ctrl_r[4:0], state_r}) & ~flt;
  // Gates allowed on per state
  function [5:0] on_set;
    input [2:0] s;
    case (s)
      3'h0: on_set = 6'h18;
      3'h1: on_set = 6'h09;
      3'h2: on_set = 6'h21;
      3'h3: on_set = 6'h24;
      3'h4: on_set = 6'h06;
      3'h5: on_set = 6'h12;
      default: on_set = 6'h00;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of software writes
  always @(posedge sys_clk) begin
    key_r <= {ctrl_r[4:0], state_r};
    if (!rst_n) begin
      ctrl_r <= 8'h00;
      state_r <= 3'h0;
      fen_r <= {NFAULT{1'b0}};
      mask_r <= 2'h0;
      dead_r <= 8'h00;
      lock_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `BCP_REG_CTRL) ctrl_r <= reg_wdata[7:0];
      if (reg_addr == `BCP_REG_STATE) state_r <= reg_wdata[2:0];
      if (reg_addr == `BCP_REG_FEN) fen_r <= reg_wdata[NFAULT-1:0];
      if (reg_addr == `BCP_REG_IMASK) mask_r <= reg_wdata[1:0];
      if (reg_addr == `BCP_REG_DEAD && !lock_r) begin
        dead_r <= reg_wdata[7:0];
        lock_r <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Only complementary and commutation modes promise open legs
  property p_no_shoot;
    !ctrl_r[3] && (ctrl_r[2] || ctrl_r[4]) |->
      !(pins[5] && pins[4]) && !(pins[3] && pins[2]) && !(pins[1] && pins[0]);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("leg both on");
  property p_fault_off;
    flt |-> pins == 6'h00;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("gate on in fault");
  property p_commut_open;
    cm |-> (pins & ~on_set(state_r)) == 6'h00;
  endproperty
  a_commut_open: assert property (p_commut_open) else $error("wrong gate on");
  property p_commut_pair;
    cm |-> (pins == 6'h00) || (pins == on_set(state_r));
  endproperty
  a_commut_pair: assert property (p_commut_pair) else $error("pair differs");
  property p_ovr_hold;
    ctrl_r[3] && !$past(reg_wr) && !$past(reg_wr, 2) && $stable(fault_in) &&
      !$past(flt, 2) |-> $stable(pins);
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("override moved");
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_dead;
    reg_rd && reg_addr == `BCP_REG_DEAD && lock_r |=> reg_rdata == {7'h00, 1'h1, dead_r};
  endproperty
  a_dead: assert property (p_dead) else $error("dead time changed");
  property p_irq_mask;
    irq |-> (mask_r != 2'h0) || ($past(mask_r) != 2'h0);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
endmodule
bind bcp_pwm bcp_pwm_monitor #(.CW(CW), .NFAULT(NFAULT)) mon_u (.sys_clk(sys_clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_in(fault_in),
  .current_sense(current_sense), .irq(irq), .top_switch_phase_a(top_switch_phase_a),
  .bottom_switch_phase_a(bottom_switch_phase_a), .top_switch_phase_b(top_switch_phase_b),
  .bottom_switch_phase_b(bottom_switch_phase_b), .top_switch_phase_c(top_switch_phase_c),
  .bottom_switch_phase_c(bottom_switch_phase_c));

// ---- bench/bcp_bridge_model.sv ----
// Behavioural three-phase inverter bridge
`timescale 1ns/1ns
module bcp_bridge_model (
  input wire sys_clk,
  input wire [5:0] gate,
  output wire [2:0] leg_open,
  output reg shoot_seen
);
  // Leg floats when neither switch conducts
  assign leg_open = {~|gate[5:4], ~|gate[3:2], ~|gate[1:0]};
  initial shoot_seen = 1'b0;
  // Latch any short across the supply
  always @(posedge sys_clk) begin
    if (&gate[5:4] || &gate[3:2] || &gate[1:0]) begin
      shoot_seen <= 1'b1;
    end
  end
endmodule

// ---- bench/bcp_pwm_tb_top.sv ----
// Self-checking testbench for the commutation PWM block
`timescale 1ns/1ns
`include "bcp_defines.vh"
`define CHK(nm, e, g) begin compares = compares + 1; if ((g) !== (e)) begin \
  mismatches = mismatches + 1; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module bcp_pwm_tb_top;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [3:0] fault_in = 4'h0;
  reg [2:0] current_sense = 3'h7;
  wire [15:0] reg_rdata;
  wire irq;
  wire [5:0] pins;
  wire [2:0] leg_open;
  wire shoot_seen;
  integer mismatches = 0;
  integer compares = 0;
  always #5 sys_clk = ~sys_clk;
  bcp_pwm dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fault_in(fault_in), .current_sense(current_sense), .irq(irq),
    .top_switch_phase_a(pins[5]), .bottom_switch_phase_a(pins[4]),
    .top_switch_phase_b(pins[3]), .bottom_switch_phase_b(pins[2]),
    .top_switch_phase_c(pins[1]), .bottom_switch_phase_c(pins[0]));
  bcp_bridge_model br_u (.sys_clk(sys_clk), .gate(pins), .leg_open(leg_open),
    .shoot_seen(shoot_seen));
  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles, entered just after an edge
  task wr(input [3:0] a, input [15:0] d);
    begin
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task rd(input [3:0] a, output [15:0] d);
    begin
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
      @(posedge sys_clk);
    end
  endtask
  // Count edges until gate b reaches level v
  task wait_pin(input integer b, input v, output integer n);
    for (n = 0; n < 300 && pins[b] !== v; n = n + 1) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  // Gates and open leg per state
  function [8:0] cm_exp(input [2:0] s);
    case (s)
      3'h0: cm_exp = {6'h18, 3'h1};
      3'h1: cm_exp = {6'h09, 3'h4};
      3'h2: cm_exp = {6'h21, 3'h2};
      3'h3: cm_exp = {6'h24, 3'h1};
      3'h4: cm_exp = {6'h06, 3'h4};
      default: cm_exp = {6'h12, 3'h2};
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset_dead;
    reg [15:0] d;
    begin
      `CHK("gates", 6'h00, pins)
      rd(`BCP_REG_MOD, d);
      `CHK("mod", 16'h0FFF, d)
      wr(`BCP_REG_DEAD, 16'h0005);
      wr(`BCP_REG_DEAD, 16'h0009);
      rd(`BCP_REG_DEAD, d);
      `CHK("dead", 16'h0105, d)
    end
  endtask
  task t_ovr;
    reg [15:0] c1;
    reg [15:0] c2;
    begin
      wr(`BCP_REG_MOD, 16'h0014);
      wr(`BCP_REG_CTRL, 16'h0089);
      wr(`BCP_REG_OVR, 16'h0021);
      #1;
      `CHK("ovr", 6'h21, pins)
      wr(`BCP_REG_OVR, 16'h0012);
      #1;
      `CHK("ovr", 6'h12, pins)
      rd(`BCP_REG_CNT, c1);
      rd(`BCP_REG_CNT, c2);
      `CHK("count runs", 1'b1, c1 !== c2)
    end
  endtask
  task t_commut;
    integer i;
    begin
      wr(`BCP_REG_DUTY0, 16'h0FFF);
      wr(`BCP_REG_STATE, 16'h0000);
      wr(`BCP_REG_CTRL, 16'h0091);
      wait_pin(5'd3, 1'b1, i);
      for (i = 0; i <= 6; i = i + 1) begin
        wr(`BCP_REG_STATE, 16'(i % 6));
        #1;
        `CHK("commut", cm_exp(3'(i % 6)), {pins, leg_open})
      end
    end
  endtask
  task t_fault;
    reg [15:0] d;
    begin
      wr(`BCP_REG_FEN, 16'h0001);
      fault_in <= 4'h2;
      @(posedge sys_clk);
      #1;
      `CHK("fault off", 6'h18, pins)
      fault_in <= 4'h1;
      #1;
      `CHK("fault at once", 6'h00, pins)
      @(posedge sys_clk);
      #1;
      `CHK("fault", 6'h00, pins)
      rd(`BCP_REG_ISTAT, d);
      `CHK("fault flag", 1'b1, d[1])
      fault_in <= 4'h0;
      wr(`BCP_REG_FEN, 16'h0000);
    end
  endtask
  task t_comp;
    integer n;
    begin
      wr(`BCP_REG_DUTY0, 16'h000A);
      wr(`BCP_REG_DUTY0 + 4'h1, 16'h000A);
      wr(`BCP_REG_CTRL, 16'h0085);
      wait_pin(5, 1'b1, n);
      wait_pin(5, 1'b0, n);
      wait_pin(4, 1'b1, n);
      `CHK("gap top", 6, n)
      wait_pin(4, 1'b0, n);
      wait_pin(5, 1'b1, n);
      `CHK("gap bottom", 6, n)
      // Negative polarity on phase a picks the zero bottom width
      wr(`BCP_REG_DUTY0 + 4'h1, 16'h0000);
      wr(`BCP_REG_CTRL, 16'h0085);
      current_sense <= 3'h6;
      repeat (45) @(posedge sys_clk);
      wait_pin(5, 1'b1, n);
      `CHK("sense bottom", 300, n)
      current_sense <= 3'h7;
      wait_pin(5, 1'b1, n);
      `CHK("sense top", 1'b1, n < 30)
    end
  endtask
  // High and low time of gate top a once the mode has settled
  task pulse(output integer hi, output integer lo);
    integer n;
    begin
      repeat (45) @(posedge sys_clk);
      #1;
      wait_pin(5, 1'b0, n);
      wait_pin(5, 1'b1, n);
      wait_pin(5, 1'b0, hi);
      wait_pin(5, 1'b1, lo);
    end
  endtask
  task t_align;
    integer hi;
    integer lo;
    begin
      wr(`BCP_REG_DUTY0, 16'h0004);
      wr(`BCP_REG_CTRL, 16'h0001);
      pulse(hi, lo);
      `CHK("edge high", 10, hi)
      `CHK("edge low", 10, lo)
      wr(`BCP_REG_CTRL, 16'h0083);
      pulse(hi, lo);
      `CHK("center high", 7, hi)
      `CHK("center low", 33, lo)
    end
  endtask
  // Edges between two reload flags
  task gap(output integer n);
    begin
      wr(`BCP_REG_ISTAT, 16'h0001);
      #1;
      for (n = 2; n < 2000 && irq !== 1'b1; n = n + 1) begin
        @(posedge sys_clk);
        #1;
      end
    end
  endtask
  task t_irq;
    reg [15:0] d;
    integer r;
    integer g;
    integer g1;
    begin
      wr(`BCP_REG_CTRL, 16'h0001);
      wr(`BCP_REG_ISTAT, 16'h0003);
      d = 16'h0000;
      for (r = 0; r < 50 && d[0] !== 1'b1; r = r + 1) rd(`BCP_REG_ISTAT, d);
      #1;
      `CHK("masked irq", 1'b0, irq)
      wr(`BCP_REG_IMASK, 16'h0001);
      #1;
      `CHK("irq", 1'b1, irq)
      for (r = 0; r < 4; r = r + 1) begin
        wr(`BCP_REG_CTRL, 16'(16'h0001 | (r << 5)));
        gap(g);
        gap(g);
        if (r == 0) g1 = g;
        `CHK("reload gap", g1 << r, g)
      end
      wr(`BCP_REG_ISTAT, 16'h0001);
      #1;
      `CHK("irq clear", 1'b0, irq)
    end
  endtask
  // Second reset reopens the write-once dead time
  task t_rst;
    reg [15:0] d;
    begin
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      wr(`BCP_REG_DEAD, 16'h0003);
      rd(`BCP_REG_DEAD, d);
      `CHK("dead after reset", 16'h0103, d)
      `CHK("irq after reset", 1'b0, irq)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset_dead;
    t_ovr;
    t_commut;
    t_fault;
    t_comp;
    t_align;
    t_irq;
    t_rst;
    `CHK("shoot", 1'b0, shoot_seen)
    give_verdict;
  end
  // Watchdog well beyond the expected run
  initial begin
    #500000;
    mismatches = mismatches + 1;
    give_verdict;
  end
endmodule
